// file: verilog/conv_cfg_regs.sv
// serial-port configuration bank with staged registers and output data formatting
//
// Summary of operation
// RULE1: format code 00 or 11 gives offset binary, 01 twos complement and 10 gray code per channel.
// RULE2: output configuration bit 6 picks CMOS (0) or LVDS (1) drivers for both channels.
// RULE3: output configuration bit 7 picks ANSI (0) or reduced (1) LVDS swing for both channels.
// RULE4: the host always writes zero to output configuration bit 3, which reads back as zero.
// RULE5: output configuration bit 4 turns off the data outputs of the selected channel.
// RULE6: output configuration bit 5 interleaves both channels onto one CMOS bus for the whole device.
// RULE7: the three-bit divider phase field delays the input clock divider by 0 to 7 input cycles.
// RULE8: the five-bit strobe delay field adds field times 2500 ps over 31 of strobe delay.
// RULE9: writes land in staging registers and are copied to the active set together on the transfer bit; channel index writes take effect at once.
// RULE10: per-channel writes go only to channels set in the channel index register, both after reset.
// RULE11: the invert bit complements every data bit of its channel after format conversion.
`timescale 1ns/10ps
`include "conv_cfg_params.svh"

module conv_cfg_regs (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic sclk,
    input wire logic csb_n,
    input wire logic sdio_in,
    output logic sdio_out,
    output logic sdio_oe_n,
    input wire logic output_disable_pin,
    input wire logic [15:0] raw_data_a,
    input wire logic [15:0] raw_data_b,
    input wire logic [7:0] signature_a,
    input wire logic [7:0] signature_b,
    output logic [15:0] data_out_a,
    output logic [15:0] data_out_b,
    output logic data_en_a,
    output logic data_en_b,
    output logic bus_carries_b,
    output conv_cfg_pkg::dev_cfg_t dev_cfg,
    output conv_cfg_pkg::chan_cfg_t chan_cfg_a,
    output conv_cfg_pkg::chan_cfg_t chan_cfg_b,
    output logic [7:0] offset_trim_a,
    output logic [7:0] offset_trim_b,
    output logic [11:0] strobe_delay_ps
);
    import conv_cfg_pkg::*;

    spi_state_t state_r;
    logic sclk_q_r;
    logic [4:0] bit_cnt_r;
    logic [22:0] shift_r;
    logic [7:0] rd_shift_r;
    logic reading_r;
    logic [12:0] addr_r;
    logic sclk_rise;
    logic sclk_fall;
    logic wr_pulse;
    logic [12:0] wr_addr;
    logic [7:0] wr_data;
    logic [7:0] rd_data;

    // channel index (immediate) and staged settings
    logic [1:0] chan_idx_r;
    dev_cfg_t dev_stage_r;
    chan_cfg_t chan_stage_r [2];
    logic [7:0] trim_stage_r [2];
    logic xfer_pulse;
    logic [1:0] fmt_rd;
    logic il_off;

    // edge detection on the serial clock, sampled as an ordinary input
    // sclk_q_r resets low like the parked serial clock, so leaving reset makes no false edge
    assign sclk_rise = sclk & ~sclk_q_r;
    assign sclk_fall = ~sclk & sclk_q_r;
    // a write commits only on the last data rise; a frame cut short leaves the staging set alone
    assign wr_pulse = (state_r == SPI_DATA) && sclk_rise && (bit_cnt_r == `SPI_FRAME_BITS - 5'd1) && !reading_r;
    assign wr_addr = addr_r;
    assign wr_data = {shift_r[6:0], sdio_in};
    assign xfer_pulse = wr_pulse && (wr_addr == `ADDR_TRANSFER) && wr_data[`TRANSFER_BIT];

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            sclk_q_r <= 1'b0;
        end else begin
            sclk_q_r <= sclk;
        end
    end

    // serial frame: 16-bit instruction (read flag, two length bits, 13-bit address) then one data byte
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            state_r <= SPI_IDLE;
            bit_cnt_r <= 5'h0;
            shift_r <= 23'h0;
            reading_r <= 1'b0;
            addr_r <= 13'h0;
        end else if (csb_n) begin
            state_r <= SPI_IDLE;
            bit_cnt_r <= 5'h0;
            reading_r <= 1'b0;
        end else if (sclk_rise) begin
            shift_r <= {shift_r[21:0], sdio_in};
            case (state_r)
                SPI_IDLE, SPI_INSTR: begin
                    state_r <= SPI_INSTR;
                    bit_cnt_r <= bit_cnt_r + 5'h1;
                    if (bit_cnt_r == `SPI_INSTR_BITS - 5'd1) begin
                        state_r <= SPI_DATA;
                        reading_r <= shift_r[14];
                        addr_r <= {shift_r[11:0], sdio_in};
                    end
                end
                SPI_DATA: begin
                    bit_cnt_r <= bit_cnt_r + 5'h1;
                    if (bit_cnt_r == `SPI_FRAME_BITS - 5'd1) begin
                        state_r <= SPI_DONE;
                    end
                end
                default: begin
                    state_r <= SPI_DONE; // extra bytes in one frame are ignored
                end
            endcase
        end
    end

    // read data leaves on falling edges, most significant bit first
    // the byte is latched at the last instruction rise, so it cannot change while it is shifted out
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            rd_shift_r <= 8'h0;
            sdio_out <= 1'b0;
            sdio_oe_n <= 1'b1;
        end else if (csb_n) begin
            sdio_oe_n <= 1'b1;
        end else if (sclk_rise && (state_r != SPI_DATA) && (bit_cnt_r == `SPI_INSTR_BITS - 5'd1)) begin
            rd_shift_r <= rd_data;
        end else if (sclk_fall && reading_r && (state_r == SPI_DATA)) begin
            sdio_out <= rd_shift_r[7];
            rd_shift_r <= {rd_shift_r[6:0], 1'b0};
            sdio_oe_n <= 1'b0;
        end else if (sclk_fall && (state_r == SPI_DONE)) begin
            sdio_oe_n <= 1'b1;
        end
    end

    // readback of staged values; local fields come from the lowest selected channel
    assign fmt_rd = chan_idx_r[0] ? chan_stage_r[0].fmt : chan_stage_r[1].fmt;
    always_comb begin
        logic [12:0] a;
        logic sel_b;
        a = {shift_r[11:0], sdio_in};
        sel_b = !chan_idx_r[0];
        rd_data = 8'h00;
        if (a == `ADDR_CHANNEL_INDEX) begin
            rd_data = {6'h00, chan_idx_r};
        end else if (a == `ADDR_SELFTEST_CONTROL) begin
            rd_data = {5'h00, dev_stage_r.selftest_reset, 1'b0, dev_stage_r.selftest_enable};
        end else if (a == `ADDR_INPUT_SERVO_CONTROL) begin
            rd_data = {7'h00, dev_stage_r.servo_enable};
        end else if (a == `ADDR_OFFSET_TRIM) begin
            rd_data = sel_b ? trim_stage_r[1] : trim_stage_r[0];
        end else if (a == `ADDR_OUTPUT_CONFIG) begin
            rd_data = {dev_stage_r.reduced_swing, dev_stage_r.lvds_mode, dev_stage_r.interleave,
                       chan_stage_r[sel_b].disable_out, 1'b0, chan_stage_r[sel_b].invert, fmt_rd}; // RULE4
        end else if (a == `ADDR_CLOCK_PHASE_CONFIG) begin
            rd_data = {dev_stage_r.strobe_invert, 4'h0, dev_stage_r.divider_phase};
        end else if (a == `ADDR_STROBE_DELAY) begin
            rd_data = {3'h0, dev_stage_r.strobe_delay};
        end else if (a == `ADDR_REFERENCE_SELECT) begin
            rd_data = {dev_stage_r.reference_sel, 6'h00};
        end else if (a == `ADDR_SELFTEST_SIGNATURE_LOW) begin
            rd_data = sel_b ? signature_b : signature_a;
        end
    end

    // channel index takes effect at once
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            chan_idx_r <= `RST_CHANNEL_INDEX; // RULE10
        end else if (wr_pulse && (wr_addr == `ADDR_CHANNEL_INDEX)) begin
            chan_idx_r <= wr_data[1:0];
        end
    end

    // staged device-wide fields
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            dev_stage_r <= '0;
            dev_stage_r.selftest_enable <= 1'(`RST_SELFTEST_CONTROL >> `SELFTEST_BIT_ENABLE);
            dev_stage_r.selftest_reset <= 1'(`RST_SELFTEST_CONTROL >> `SELFTEST_BIT_RESET);
            dev_stage_r.reference_sel <= 2'(`RST_REFERENCE_SELECT >> 6);
        end else if (wr_pulse) begin
            if (wr_addr == `ADDR_SELFTEST_CONTROL) begin
                dev_stage_r.selftest_enable <= wr_data[`SELFTEST_BIT_ENABLE];
                dev_stage_r.selftest_reset <= wr_data[`SELFTEST_BIT_RESET];
            end else if (wr_addr == `ADDR_INPUT_SERVO_CONTROL) begin
                dev_stage_r.servo_enable <= wr_data[0];
            end else if (wr_addr == `ADDR_OUTPUT_CONFIG) begin
                dev_stage_r.reduced_swing <= wr_data[`OUT_BIT_REDUCED]; // RULE3
                dev_stage_r.lvds_mode <= wr_data[`OUT_BIT_LVDS]; // RULE2
                dev_stage_r.interleave <= wr_data[`OUT_BIT_INTERLEAVE]; // RULE6
            end else if (wr_addr == `ADDR_CLOCK_PHASE_CONFIG) begin
                dev_stage_r.strobe_invert <= wr_data[`PHASE_BIT_STROBE_INV];
                dev_stage_r.divider_phase <= wr_data[2:0]; // RULE7
            end else if (wr_addr == `ADDR_STROBE_DELAY) begin
                dev_stage_r.strobe_delay <= wr_data[4:0]; // RULE8
            end else if (wr_addr == `ADDR_REFERENCE_SELECT) begin
                dev_stage_r.reference_sel <= wr_data[7:6];
            end
        end
    end

    // staged per-channel fields, written only where the channel index bit is set
    // with both index bits set, as after reset, one write lands in both channels
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            for (int i = 0; i < 2; i++) begin
                chan_stage_r[i] <= '0;
                trim_stage_r[i] <= 8'h00;
            end
        end else if (wr_pulse) begin
            for (int i = 0; i < 2; i++) begin
                if (chan_idx_r[i] && (wr_addr == `ADDR_OUTPUT_CONFIG)) begin // RULE10
                    chan_stage_r[i].fmt <= wr_data[`OUT_BIT_FMT_LSB +: 2];
                    chan_stage_r[i].invert <= wr_data[`OUT_BIT_INVERT];
                    chan_stage_r[i].disable_out <= wr_data[`OUT_BIT_DISABLE]; // RULE5
                end else if (chan_idx_r[i] && (wr_addr == `ADDR_OFFSET_TRIM)) begin // RULE10
                    trim_stage_r[i] <= wr_data;
                end
            end
        end
    end

    // transfer copies every staged value to the active set in one cycle
    // the transfer bit itself is not stored, so it reads back as zero
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            dev_cfg <= '0;
            dev_cfg.selftest_enable <= 1'(`RST_SELFTEST_CONTROL >> `SELFTEST_BIT_ENABLE);
            dev_cfg.selftest_reset <= 1'(`RST_SELFTEST_CONTROL >> `SELFTEST_BIT_RESET);
            dev_cfg.reference_sel <= 2'(`RST_REFERENCE_SELECT >> 6);
            chan_cfg_a <= '0;
            chan_cfg_b <= '0;
            offset_trim_a <= 8'h00;
            offset_trim_b <= 8'h00;
        end else if (xfer_pulse) begin // RULE9
            dev_cfg <= dev_stage_r;
            chan_cfg_a <= chan_stage_r[0];
            chan_cfg_b <= chan_stage_r[1];
            offset_trim_a <= trim_stage_r[0];
            offset_trim_b <= trim_stage_r[1];
        end
    end

    // strobe delay in picoseconds from the active code
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            strobe_delay_ps <= 12'h000;
        end else begin
            // half a step is added so the value rounds to the nearest picosecond, code 1 giving 81
            strobe_delay_ps <= 12'((17'(dev_cfg.strobe_delay) * `STROBE_FULL_PS + (`STROBE_STEPS >> 1))
                                   / `STROBE_STEPS); // RULE8
        end
    end

    // format conversion from offset binary raw samples
    function automatic logic [15:0] fmt_conv(input logic [15:0] raw, input chan_cfg_t c);
        logic [15:0] v;
        v = raw; // RULE1
        if (c.fmt == `FMT_TWOS) begin
            v = {~raw[15], raw[14:0]}; // RULE1
        end else if (c.fmt == `FMT_GRAY) begin
            v = raw ^ {1'b0, raw[15:1]}; // RULE1
        end
        return c.invert ? ~v : v; // RULE11
    endfunction

    // in interleave the bus follows the disable of whichever channel it carries next
    assign il_off = output_disable_pin || (bus_carries_b ? chan_cfg_a.disable_out : chan_cfg_b.disable_out);

    // output bus: interleave alternates both channels onto bus a and parks bus b
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            data_out_a <= 16'h0000;
            data_out_b <= 16'h0000;
            data_en_a <= 1'b0;
            data_en_b <= 1'b0;
            bus_carries_b <= 1'b0;
        end else if (dev_cfg.interleave && !dev_cfg.lvds_mode) begin // RULE6
            bus_carries_b <= !bus_carries_b;
            if (il_off) begin
                data_out_a <= 16'h0000; // RULE5
            end else begin
                data_out_a <= bus_carries_b ? fmt_conv(raw_data_a, chan_cfg_a) : fmt_conv(raw_data_b, chan_cfg_b);
            end
            data_en_a <= !il_off; // RULE5
            data_out_b <= 16'h0000;
            data_en_b <= 1'b0;
        end else begin
            bus_carries_b <= 1'b0;
            data_en_a <= !output_disable_pin && !chan_cfg_a.disable_out; // RULE5
            data_en_b <= !output_disable_pin && !chan_cfg_b.disable_out; // RULE5
            data_out_a <= (output_disable_pin || chan_cfg_a.disable_out) ? 16'h0000 : fmt_conv(raw_data_a, chan_cfg_a);
            data_out_b <= (output_disable_pin || chan_cfg_b.disable_out) ? 16'h0000 : fmt_conv(raw_data_b, chan_cfg_b);
        end
    end

endmodule

// file: verilog/conv_cfg_params.svh
// register offsets, field positions, reset values and timing figures of the converter configuration bank
`ifndef CONV_CFG_PARAMS_SVH
`define CONV_CFG_PARAMS_SVH

`define ADDR_CHANNEL_INDEX 13'h005
`define ADDR_TRANSFER 13'h0ff
`define ADDR_SELFTEST_CONTROL 13'h00e
`define ADDR_INPUT_SERVO_CONTROL 13'h00f
`define ADDR_OFFSET_TRIM 13'h010
`define ADDR_OUTPUT_CONFIG 13'h014
`define ADDR_CLOCK_PHASE_CONFIG 13'h016
`define ADDR_STROBE_DELAY 13'h017
`define ADDR_REFERENCE_SELECT 13'h018
`define ADDR_SELFTEST_SIGNATURE_LOW 13'h024

`define RST_CHANNEL_INDEX 2'h3
`define RST_SELFTEST_CONTROL 8'h04
`define RST_REFERENCE_SELECT 8'hc0

`define OUT_BIT_FMT_LSB 0
`define OUT_BIT_INVERT 2
`define OUT_BIT_DISABLE 4
`define OUT_BIT_INTERLEAVE 5
`define OUT_BIT_LVDS 6
`define OUT_BIT_REDUCED 7
`define PHASE_BIT_STROBE_INV 7
`define SELFTEST_BIT_ENABLE 0
`define SELFTEST_BIT_RESET 2
`define TRANSFER_BIT 0

`define FMT_OFFSET_A 2'h0
`define FMT_TWOS 2'h1
`define FMT_GRAY 2'h2
`define FMT_OFFSET_B 2'h3

`define STROBE_FULL_PS 17'd2500
`define STROBE_STEPS 17'd31

`define SPI_INSTR_BITS 5'd16
`define SPI_FRAME_BITS 5'd24

`endif

// file: verilog/conv_cfg_pkg.sv
// types shared by the converter configuration bank
package conv_cfg_pkg;

    // per-channel output settings
    typedef struct packed {
        logic invert;
        logic disable_out;
        logic [1:0] fmt;
    } chan_cfg_t;

    // device-wide settings
    typedef struct packed {
        logic reduced_swing;
        logic lvds_mode;
        logic interleave;
        logic strobe_invert;
        logic [2:0] divider_phase;
        logic [4:0] strobe_delay;
        logic selftest_enable;
        logic selftest_reset;
        logic servo_enable;
        logic [1:0] reference_sel;
    } dev_cfg_t;

    typedef enum logic [1:0] {SPI_IDLE, SPI_INSTR, SPI_DATA, SPI_DONE} spi_state_t;

endpackage

// file: sim/conv_cfg_regs_asserts.sv
// port-level checks on the converter configuration bank
`timescale 1ns/10ps
`include "conv_cfg_params.svh"
module conv_cfg_regs_asserts (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic sclk,
    input wire logic csb_n,
    input wire logic sdio_oe_n,
    input wire logic output_disable_pin,
    input wire logic [15:0] raw_data_a,
    input wire logic [15:0] raw_data_b,
    input wire logic [15:0] data_out_a,
    input wire logic [15:0] data_out_b,
    input wire logic data_en_a,
    input wire logic data_en_b,
    input wire logic bus_carries_b,
    input wire conv_cfg_pkg::dev_cfg_t dev_cfg,
    input wire conv_cfg_pkg::chan_cfg_t chan_cfg_a,
    input wire conv_cfg_pkg::chan_cfg_t chan_cfg_b,
    input wire logic [11:0] strobe_delay_ps
);
    import conv_cfg_pkg::*;
    logic il;
    logic [16:0] ps_exp;
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    // interleave only counts on the cmos bus; strobe delay in ps
    assign il = dev_cfg.interleave & ~dev_cfg.lvds_mode;
    assign ps_exp = ({12'h0, dev_cfg.strobe_delay} * `STROBE_FULL_PS + (`STROBE_STEPS >> 1)) / `STROBE_STEPS;
    // format then optional complement
    function automatic logic [15:0] fm(input chan_cfg_t c, input logic [15:0] r);
        logic [15:0] v;
        v = (c.fmt == `FMT_TWOS) ? r ^ 16'h8000 : (c.fmt == `FMT_GRAY) ? r ^ (r >> 1) : r;
        return v ^ {16{c.invert}};
    endfunction
    a_fmt_chan_a: assert property (!il && !output_disable_pin && !chan_cfg_a.disable_out |=>
        data_en_a && data_out_a == fm($past(chan_cfg_a), $past(raw_data_a))) else $error("channel a data wrong");
    a_fmt_chan_b: assert property (!il && !output_disable_pin && !chan_cfg_b.disable_out |=>
        data_en_b && data_out_b == fm($past(chan_cfg_b), $past(raw_data_b))) else $error("channel b data wrong");
    a_disable_a: assert property (!il && (output_disable_pin || chan_cfg_a.disable_out) |=>
        data_out_a == 16'h0 && !data_en_a) else $error("channel a not turned off");
    a_disable_b: assert property (!il && (output_disable_pin || chan_cfg_b.disable_out) |=>
        data_out_b == 16'h0 && !data_en_b) else $error("channel b not turned off");
    a_il_bus_idle: assert property (il |=> data_out_b == 16'h0 && !data_en_b) else $error("b bus active");
    a_il_toggle: assert property (il && $past(il) |-> bus_carries_b != $past(bus_carries_b))
        else $error("interleave select stuck");
    a_strobe_ps: assert property (strobe_delay_ps == $past(ps_exp[11:0])) else $error("strobe ps wrong");
    a_cfg_on_xfer: assert property (!$stable({dev_cfg, chan_cfg_a, chan_cfg_b}) |->
        $past(sclk) && !$past(csb_n)) else $error("active settings moved outside a frame");
    a_oe_idle: assert property (csb_n && $past(csb_n) |-> sdio_oe_n) else $error("sdio driven while idle");
    c_il: cover property (il ##1 il);
    c_xfer: cover property (!$stable(dev_cfg));
    c_read: cover property (!sdio_oe_n);
endmodule

bind conv_cfg_regs conv_cfg_regs_asserts i_conv_cfg_regs_asserts (.clock, .reset_n, .sclk, .csb_n, .sdio_oe_n,
    .output_disable_pin, .raw_data_a, .raw_data_b, .data_out_a, .data_out_b, .data_en_a, .data_en_b,
    .bus_carries_b, .dev_cfg, .chan_cfg_a, .chan_cfg_b, .strobe_delay_ps);

// file: sim/spi_host_model.sv
// serial port host that frames single-byte register reads and writes
`timescale 1ns/10ps
`include "conv_cfg_params.svh"
module spi_host_model (
    input wire logic clock,
    input wire logic sdio_out,
    input wire logic sdio_oe_n,
    output logic sclk,
    output logic csb_n,
    output logic sdio_in
);
    logic hb = 1'b1;
    // resolved data wire: the device wins while its enable is low
    assign sdio_in = sdio_oe_n ? hb : sdio_out;
    // idle: clock parked low, chip select high
    initial begin
        sclk = 1'b0;
        csb_n = 1'b1;
    end
    // 24 bits, 2 cycles low and 2 high per bit; a read returns the data byte
    task automatic xfer(input logic rd, input logic [12:0] a, input logic [7:0] d, output logic [7:0] q);
        logic [23:0] f;
        f = {rd, 2'b00, a, (!rd && a == `ADDR_OUTPUT_CONFIG) ? d & 8'hf7 : d};
        q = 8'h00;
        @(posedge clock) #1 csb_n = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            @(posedge clock) #1 sclk = 1'b0;
            hb = (rd && i < 8) ? ~hb : f[i];
            repeat (2) @(posedge clock);
            #1 sclk = 1'b1;
            @(posedge clock) #2;
            if (i < 8) q[i] = sdio_in;
        end
        @(posedge clock) #1 sclk = 1'b0;
        hb = ~hb;
        repeat (2) @(posedge clock);
        #1 csb_n = 1'b1;
        repeat (2) @(posedge clock);
    endtask
endmodule

// file: sim/testbench.sv
// self-checking bench for the converter configuration bank
`timescale 1ns/10ps
`include "conv_cfg_params.svh"
module testbench;
    import conv_cfg_pkg::*;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic output_disable_pin = 1'b0;
    logic sclk, csb_n, sdio_in, sdio_out, sdio_oe_n, data_en_a, data_en_b, bus_carries_b;
    logic [15:0] raw_data_a = 16'h0, raw_data_b = 16'h0, data_out_a, data_out_b;
    logic [7:0] signature_a = 8'h5a, signature_b = 8'hc3, offset_trim_a, offset_trim_b, r;
    logic [11:0] strobe_delay_ps;
    dev_cfg_t dev_cfg, ed;
    chan_cfg_t chan_cfg_a, chan_cfg_b, eca, ecb;
    logic [7:0] ga[int], la[int], lb[int], eta, etb;
    logic [1:0] ci = 2'h3;
    integer seed = 32'h7f05ccbf;
    int err_total = 0;
    int n_checks = 0;
    logic [12:0] ad[7] = '{13'h00e, 13'h00f, 13'h010, 13'h014, 13'h016, 13'h017, 13'h018};
    logic [7:0] mk[7] = '{8'h05, 8'h01, 8'hff, 8'hf7, 8'h87, 8'h1f, 8'hc0};
    conv_cfg_regs i_conv_cfg_regs (.clock, .reset_n, .sclk, .csb_n, .sdio_in, .sdio_out, .sdio_oe_n,
        .output_disable_pin, .raw_data_a, .raw_data_b, .signature_a, .signature_b, .data_out_a, .data_out_b,
        .data_en_a, .data_en_b, .bus_carries_b, .dev_cfg, .chan_cfg_a, .chan_cfg_b, .offset_trim_a,
        .offset_trim_b, .strobe_delay_ps);
    spi_host_model host (.clock, .sdio_out, .sdio_oe_n, .sclk, .csb_n, .sdio_in);
    // clock and fresh samples each cycle
    always #20 clock = ~clock;
    always @(posedge clock) begin
        #1 raw_data_a = $random(seed);
        raw_data_b = $random(seed);
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            err_total++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // staged set copied to expected active set
    task automatic act();
        ed = {la[13'h014][7:5], ga[13'h016][7], ga[13'h016][2:0], ga[13'h017][4:0], ga[13'h00e][0],
              ga[13'h00e][2], ga[13'h00f][0], ga[13'h018][7:6]};
        eca = {la[13'h014][2], la[13'h014][4], la[13'h014][1:0]};
        ecb = {lb[13'h014][2], lb[13'h014][4], lb[13'h014][1:0]};
        eta = la[13'h010];
        etb = lb[13'h010];
    endtask
    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        logic [7:0] q;
        host.xfer(1'b0, a, d, q);
        if (a == `ADDR_OUTPUT_CONFIG) d[3] = 1'b0;
        if (a == `ADDR_CHANNEL_INDEX) ci = d[1:0];
        else if (a == `ADDR_TRANSFER && d[0]) act();
        else if (la.exists(a)) begin
            if (ci[0]) la[a] = d;
            if (ci[1]) lb[a] = d;
        end else if (ga.exists(a)) ga[a] = d;
    endtask
    function automatic logic [7:0] erd(input logic [12:0] a);
        if (a == `ADDR_CHANNEL_INDEX) return {6'h00, ci};
        if (a == `ADDR_SELFTEST_SIGNATURE_LOW) return ci[0] ? signature_a : signature_b;
        if (la.exists(a)) return ci[0] ? la[a] : lb[a];
        if (ga.exists(a)) return ga[a];
        return 8'h00;
    endfunction
    task automatic rd(input logic [12:0] a);
        logic [7:0] q;
        host.xfer(1'b1, a, 8'h00, q);
        chk(q, erd(a));
    endtask
    task automatic ccfg();
        chk(dev_cfg, ed);
        chk({chan_cfg_a, chan_cfg_b, offset_trim_a, offset_trim_b}, {eca, ecb, eta, etb});
        chk(strobe_delay_ps, (ed.strobe_delay * 2500 + 15) / 31);
    endtask
    function automatic logic [15:0] fx(input chan_cfg_t c, input logic [15:0] x);
        logic [15:0] v;
        case (c.fmt)
            2'h1: v = {~x[15], x[14:0]};
            2'h2: v = x ^ {1'b0, x[15:1]};
            default: v = x;
        endcase
        return c.invert ? ~v : v;
    endfunction
    task automatic dchk();
        logic [15:0] ra, rb;
        logic cb, off;
        @(posedge clock) #2;
        ra = raw_data_a;
        rb = raw_data_b;
        cb = bus_carries_b;
        @(posedge clock) #2;
        if (ed.interleave && !ed.lvds_mode) begin
            off = output_disable_pin | (cb ? eca.disable_out : ecb.disable_out);
            chk({data_en_b, data_out_b}, 17'h0);
            chk(bus_carries_b, !cb);
            chk({data_en_a, data_out_a}, off ? 17'h0 : {1'b1, cb ? fx(eca, ra) : fx(ecb, rb)});
        end else begin
            chk({data_en_a, data_out_a}, (output_disable_pin | eca.disable_out) ? 17'h0 : {1'b1, fx(eca, ra)});
            chk({data_en_b, data_out_b}, (output_disable_pin | ecb.disable_out) ? 17'h0 : {1'b1, fx(ecb, rb)});
        end
    endtask
    // hang guard
    initial begin
        repeat (90000) @(posedge clock);
        err_total++;
        close_out();
    end
    // main sequence
    initial begin
        for (int k = 0; k < 7; k++) ga[ad[k]] = (k == 0) ? 8'h04 : (k == 6) ? 8'hc0 : 8'h00;
        la[13'h010] = 8'h00;
        la[13'h014] = 8'h00;
        lb = la;
        repeat (6) @(posedge clock);
        #1 reset_n = 1'b1;
        act();
        ccfg();
        rd(`ADDR_CHANNEL_INDEX);
        wr(`ADDR_OFFSET_TRIM, 8'h3c);
        for (int i = 0; i < 8; i++) begin
            for (int k = 0; k < 7; k++) rd(ad[k]);
            rd(`ADDR_SELFTEST_SIGNATURE_LOW);
            rd(13'h033);
            r = $random(seed);
            wr(`ADDR_CHANNEL_INDEX, 8'h01);
            wr(`ADDR_OUTPUT_CONFIG, {r[7], i[1], i[0], i == 6, 1'b1, r[2], i[1:0]});
            wr(`ADDR_CHANNEL_INDEX, 8'h02);
            wr(`ADDR_OUTPUT_CONFIG, {r[7], i[1], i[0], r[4], 1'b1, r[3], ~i[1:0]});
            for (int k = 0; k < 7; k++) begin
                r = $random(seed);
                if (k != 3) wr(ad[k], r & mk[k]);
            end
            wr(`ADDR_SELFTEST_SIGNATURE_LOW, r);
            wr(13'h033, r);
            rd(13'h010);
            rd(13'h014);
            ccfg();
            wr(`ADDR_CHANNEL_INDEX, {7'h0, i[2]} + 8'h01);
            wr(`ADDR_TRANSFER, 8'h01);
            ccfg();
            @(posedge clock) #1 output_disable_pin = (i == 5);
            repeat (4) dchk();
        end
        close_out();
    end
endmodule
